// ===== dpram_defines.vh
// Constants for the dual-port block memory
// What this block does
// - One array of 4096 bit cells, shared by both ports.
// - Each port may be read/write, read-only or write-only, with own width.
// - Widths 1,2,4,8,16 pair with depths 4096..256; address 12 to 8 bits.
// - Single port of any width, or dual with second port at least as wide.
// - All port inputs are sampled on that port's own clock edge only.
// - A read captures address on the edge and shows the cell after it.
// - No combinational path from address to data output.
// - Ports are fully independent with no arbitration.
// - A read or a write completes on a single clock edge.
// - Output holds its value until the next enabled operation on the port.
// - With enable inactive, no array write and no output change.
// - Enable gates read, write and output reset alike.
// - Write stores data-in and mirrors it on output; else read to output.
// - Port reset zeroes that port's output only; array and other port untouched.
// - Each port times outputs and samples inputs on its own clock.
// - Highest bit covered is (address + 1) times width, minus one.
// - Same-cell write-write is invalid; write-read gives invalid read data.
// - Clock, enable, write-enable and reset each have a polarity option.
// - Contents may be preset; anything not preset starts as zero.
`ifndef DPRAM_DEFINES_VH
`define DPRAM_DEFINES_VH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define DPR_MEM_BITS    4096
`define DPR_IDX_BITS    13
`define DPR_MAX_ABITS   12
`define DPR_MAX_WIDTH   16

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define DPR_PADDR_BITS  12
`define DPR_CTRL_OFF    12'h000
`define DPR_STATUS_OFF  12'h004
`define DPR_CTRL_RST    4'h0
`define DPR_STATUS_RST  4'h0

// Control bits
`define DPR_CTRL_RO_A   0
`define DPR_CTRL_RO_B   1
`define DPR_CTRL_WO_A   2
`define DPR_CTRL_WO_B   3

// Status bits, write one to clear
`define DPR_ST_WW       0
`define DPR_ST_WR       1
`define DPR_ST_BAD_A    2
`define DPR_ST_BAD_B    3
`define DPR_REG_BITS    4

`endif

// ===== dual_port_block_ram.v
// Dual-port block memory with APB control and collision status
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "dpram_defines.vh"

module dual_port_block_ram #(
    parameter                      WIDTH_A   = 1,
    parameter                      WIDTH_B   = 16,
    parameter                      CLK_INV_A = 0,
    parameter                      EN_INV_A  = 0,
    parameter                      WE_INV_A  = 0,
    parameter                      RST_INV_A = 0,
    parameter                      CLK_INV_B = 0,
    parameter                      EN_INV_B  = 0,
    parameter                      WE_INV_B  = 0,
    parameter                      RST_INV_B = 0,
    parameter [`DPR_MEM_BITS-1:0]  INIT_BITS = {`DPR_MEM_BITS{1'b0}},
    // Address widths follow the port widths; ports need them before any localparam
    parameter                      AW_A      = `DPR_MAX_ABITS - ((WIDTH_A >= 16) ? 4 :
                                               (WIDTH_A >= 8) ? 3 : (WIDTH_A >= 4) ? 2 :
                                               (WIDTH_A >= 2) ? 1 : 0),
    parameter                      AW_B      = `DPR_MAX_ABITS - ((WIDTH_B >= 16) ? 4 :
                                               (WIDTH_B >= 8) ? 3 : (WIDTH_B >= 4) ? 2 :
                                               (WIDTH_B >= 2) ? 1 : 0)
) (
    input  wire                        mclk_i,
    input  wire                        rst_b_i,
    // APB slave
    input  wire [`DPR_PADDR_BITS-1:0]  paddr_i,
    input  wire                        psel_i,
    input  wire                        penable_i,
    input  wire                        pwrite_i,
    input  wire [31:0]                 pwdata_i,
    output wire [31:0]                 prdata_o,
    output wire                        pready_o,
    output wire                        pslverr_o,
    // Port A
    input  wire                        port_clock_a_i,
    input  wire                        en_a_i,
    input  wire                        we_a_i,
    input  wire                        rst_a_i,
    input  wire [AW_A-1:0]             addr_a_i,
    input  wire [WIDTH_A-1:0]          port_data_in_a_i,
    output wire [WIDTH_A-1:0]          data_a_o,
    // Port B
    input  wire                        port_clock_b_i,
    input  wire                        en_b_i,
    input  wire                        we_b_i,
    input  wire                        rst_b_port_i,
    input  wire [AW_B-1:0]             addr_b_i,
    input  wire [WIDTH_B-1:0]          port_data_in_b_i,
    output wire [WIDTH_B-1:0]          data_b_o
);

    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    function integer lg2;
        input integer v;
        integer i;
        begin
            lg2 = 0;
            for (i = 1; i < v; i = i * 2)
                lg2 = lg2 + 1;
        end
    endfunction

    localparam                     LG_A = lg2(WIDTH_A);
    localparam                     LG_B = lg2(WIDTH_B);
    localparam [`DPR_IDX_BITS-1:0] W_A  = WIDTH_A;
    localparam [`DPR_IDX_BITS-1:0] W_B  = WIDTH_B;

    // ----------------------------------------------------------------
    // Port input conditioning
    // ----------------------------------------------------------------
    // Port clocks are sampled on mclk_i; a port edge is a rising edge of
    // the conditioned clock, so each port keeps its own timing.
    wire clk_a = port_clock_a_i ^ (CLK_INV_A != 0);
    wire clk_b = port_clock_b_i ^ (CLK_INV_B != 0);
    wire en_a  = en_a_i ^ (EN_INV_A != 0);
    wire en_b  = en_b_i ^ (EN_INV_B != 0);
    wire we_a  = we_a_i ^ (WE_INV_A != 0);
    wire we_b  = we_b_i ^ (WE_INV_B != 0);
    wire rs_a  = rst_a_i ^ (RST_INV_A != 0);
    wire rs_b  = rst_b_port_i ^ (RST_INV_B != 0);

    reg                          clk_a_q;
    reg                          clk_b_q;
    reg  [`DPR_REG_BITS-1:0]     ctrl_q;
    reg  [`DPR_REG_BITS-1:0]     status_q;
    reg  [`DPR_REG_BITS-1:0]     status_d;
    reg  [31:0]                  prdata_q;
    reg  [`DPR_MEM_BITS-1:0]     mem_q;
    reg  [`DPR_MEM_BITS-1:0]     mem_d;
    reg  [`DPR_MEM_BITS-1:0]     poison_q;
    reg  [`DPR_MEM_BITS-1:0]     poison_d;
    reg  [WIDTH_A-1:0]           dout_a_q;
    reg  [WIDTH_B-1:0]           dout_b_q;
    reg  [WIDTH_A-1:0]           rdata_a;
    reg  [WIDTH_B-1:0]           rdata_b;
    reg                          bad_a;
    reg                          bad_b;
    integer                      k;

    // Enable gates every port function.
    wire act_a = clk_a & ~clk_a_q & en_a;
    wire act_b = clk_b & ~clk_b_q & en_b;

    // Read-only strips writes, write-only strips reads.
    wire we_eff_a = we_a & ~ctrl_q[`DPR_CTRL_RO_A];
    wire we_eff_b = we_b & ~ctrl_q[`DPR_CTRL_RO_B];
    wire wr_a     = act_a & we_eff_a;
    wire wr_b     = act_b & we_eff_b;
    wire rd_a     = act_a & ~we_eff_a & ~ctrl_q[`DPR_CTRL_WO_A];
    wire rd_b     = act_b & ~we_eff_b & ~ctrl_q[`DPR_CTRL_WO_B];

    // ----------------------------------------------------------------
    // Address mapping onto the shared array
    // ----------------------------------------------------------------
    // Lowest bit is address times width, so the top bit is
    // (address + 1) * width - 1.
    wire [`DPR_IDX_BITS-1:0] lo_a = {{(`DPR_IDX_BITS-AW_A){1'b0}}, addr_a_i} << LG_A;
    wire [`DPR_IDX_BITS-1:0] lo_b = {{(`DPR_IDX_BITS-AW_B){1'b0}}, addr_b_i} << LG_B;
    wire [`DPR_IDX_BITS-1:0] hi_a = lo_a + W_A;
    wire [`DPR_IDX_BITS-1:0] hi_b = lo_b + W_B;
    wire                     overlap = (lo_a < hi_b) && (lo_b < hi_a);

    // Both edges in one sampling cycle on overlapping bits, a write against a write or a read, count as a clock-to-clock violation.
    wire ww_hit = wr_a & wr_b & overlap;
    wire wr_hit = overlap & ((wr_a & rd_b) | (wr_b & rd_a));

    // ----------------------------------------------------------------
    // Array next state and read paths
    // ----------------------------------------------------------------
    // One process owns the array, so both ports write it without any
    // arbitration; only the collision bookkeeping looks at both.
    always @*
    begin
        mem_d    = mem_q;
        poison_d = poison_q;
        rdata_a  = {WIDTH_A{1'b0}};
        rdata_b  = {WIDTH_B{1'b0}};
        bad_a    = 1'b0;
        bad_b    = 1'b0;
        for (k = 0; k < WIDTH_A; k = k + 1)
        begin
            rdata_a[k] = mem_q[lo_a + k];
            bad_a      = bad_a | poison_q[lo_a + k];
            if (wr_a)
            begin
                mem_d[lo_a + k]    = port_data_in_a_i[k];
                poison_d[lo_a + k] = 1'b0;
            end
        end
        for (k = 0; k < WIDTH_B; k = k + 1)
        begin
            rdata_b[k] = mem_q[lo_b + k];
            bad_b      = bad_b | poison_q[lo_b + k];
            if (wr_b)
            begin
                mem_d[lo_b + k]    = port_data_in_b_i[k];
                poison_d[lo_b + k] = 1'b0;
            end
        end
        // Only the shared bits are spoiled; this stays right even if a
        // narrower port B is configured against the pairing rule.
        if (ww_hit)
        begin
            for (k = 0; k < WIDTH_B; k = k + 1)
            begin
                if ((lo_b + k >= lo_a) && (lo_b + k < hi_a))
                    poison_d[lo_b + k] = 1'b1;
            end
        end
    end

    // Array storage; reset stands for configuration.
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            mem_q    <= INIT_BITS;
            poison_q <= {`DPR_MEM_BITS{1'b0}};
        end
        else
        begin
            mem_q    <= mem_d;
            poison_q <= poison_d;
        end
    end

    // ----------------------------------------------------------------
    // Port edge history
    // ----------------------------------------------------------------
    // History starts low, so a port clock already high at release is
    // taken as an edge on the first mclk_i cycle after release.
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            clk_a_q <= 1'b0;
            clk_b_q <= 1'b0;
        end
        else
        begin
            clk_a_q <= clk_a;
            clk_b_q <= clk_b;
        end
    end

    // ----------------------------------------------------------------
    // Port output latches
    // ----------------------------------------------------------------
    // Apart from rst_b_i, outputs only change on an enabled port edge, never from the
    // address directly.
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dout_a_q <= {WIDTH_A{1'b0}};
        end
        else if (act_a)
        begin
            if (rs_a)
                dout_a_q <= {WIDTH_A{1'b0}};
            else if (we_eff_a)
                dout_a_q <= port_data_in_a_i;
            else if (rd_a)
                dout_a_q <= rdata_a;
        end
    end

    // Port B has its own latch, so its reset never touches port A.
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dout_b_q <= {WIDTH_B{1'b0}};
        end
        else if (act_b)
        begin
            if (rs_b)
                dout_b_q <= {WIDTH_B{1'b0}};
            else if (we_eff_b)
                dout_b_q <= port_data_in_b_i;
            else if (rd_b)
                dout_b_q <= rdata_b;
        end
    end

    assign data_a_o = dout_a_q;
    assign data_b_o = dout_b_q;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Zero wait states keep the slave trivial; read data is captured in
    // the setup cycle so prdata_o comes straight from a flop.
    wire hit_ctrl   = (paddr_i == `DPR_CTRL_OFF);
    wire hit_status = (paddr_i == `DPR_STATUS_OFF);
    wire access     = psel_i & penable_i;
    wire setup_rd   = psel_i & ~penable_i & ~pwrite_i;
    wire wr_ctrl    = access & pwrite_i & hit_ctrl;
    wire wr_status  = access & pwrite_i & hit_status;

    // ----------------------------------------------------------------
    // Collision status
    // ----------------------------------------------------------------
    // Sticky collision flags: a new event wins over a same-cycle clear.
    always @*
    begin
        status_d = status_q;
        if (wr_status)
            status_d = status_q & ~pwdata_i[`DPR_REG_BITS-1:0];
        if (ww_hit)
            status_d[`DPR_ST_WW] = 1'b1;
        if (wr_hit)
            status_d[`DPR_ST_WR] = 1'b1;
        if (rd_a & bad_a)
            status_d[`DPR_ST_BAD_A] = 1'b1;
        if (rd_b & bad_b)
            status_d[`DPR_ST_BAD_B] = 1'b1;
    end

    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            status_q <= `DPR_STATUS_RST;
        end
        else
        begin
            status_q <= status_d;
        end
    end

    // ----------------------------------------------------------------
    // Port mode control
    // ----------------------------------------------------------------
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl_q <= `DPR_CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= pwdata_i[`DPR_REG_BITS-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Unmapped reads return zero alongside the error flag.
    always @(posedge mclk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prdata_q <= 32'h00000000;
        end
        else if (setup_rd)
        begin
            if (hit_ctrl)
                prdata_q <= {{(32-`DPR_REG_BITS){1'b0}}, ctrl_q};
            else if (hit_status)
                prdata_q <= {{(32-`DPR_REG_BITS){1'b0}}, status_d};
            else
                prdata_q <= 32'h00000000;
        end
    end

    assign prdata_o  = prdata_q;
    assign pready_o  = 1'b1;
    assign pslverr_o = access & ~hit_ctrl & ~hit_status;

endmodule // dual_port_block_ram

// ===== dpram_chk.sv
// Assertion checker for the dual-port block memory
`timescale 1ns/10ps
`include "dpram_defines.vh"
module dpram_chk #(
    parameter WIDTH_A = 1,
    parameter WIDTH_B = 16
) (
    input logic                         mclk_i,
    input logic                         rst_b_i,
    input logic [`DPR_PADDR_BITS-1:0]   paddr_i,
    input logic                         psel_i,
    input logic                         penable_i,
    input logic                         pready_o,
    input logic                         pslverr_o,
    input logic                         port_clock_a_i,
    input logic                         en_a_i,
    input logic                         we_a_i,
    input logic                         rst_a_i,
    input logic [WIDTH_A-1:0]           port_data_in_a_i,
    input logic [WIDTH_A-1:0]           data_a_o,
    input logic                         port_clock_b_i,
    input logic                         en_b_i,
    input logic                         we_b_i,
    input logic                         rst_b_port_i,
    input logic [WIDTH_B-1:0]           port_data_in_b_i,
    input logic [WIDTH_B-1:0]           data_b_o
);
    // ------------------------------------------------------------
    // Port edge detection, history cleared while in reset
    // ------------------------------------------------------------
    logic [1:0] clk_q;
    always_ff @(posedge mclk_i) clk_q <= {port_clock_b_i, port_clock_a_i} & {2{rst_b_i}};
    wire take_a = port_clock_a_i & ~clk_q[0] & en_a_i;
    wire take_b = port_clock_b_i & ~clk_q[1] & en_b_i;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence wr_a_seq; take_a && we_a_i && !rst_a_i; endsequence
    sequence wr_b_seq; take_b && we_b_i && !rst_b_port_i; endsequence
    sequence acc_seq; psel_i && penable_i; endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_hold_out_a: assert property (!take_a |=> $stable(data_a_o))
        else $error("port A output moved without an enabled edge");
    a_hold_out_b: assert property (!take_b |=> $stable(data_b_o))
        else $error("port B output moved without an enabled edge");
    a_mirror_a: assert property (wr_a_seq |=> data_a_o == $past(port_data_in_a_i))
        else $error("port A write not mirrored");
    a_mirror_b: assert property (wr_b_seq |=> data_b_o == $past(port_data_in_b_i))
        else $error("port B write not mirrored");
    a_clear_a: assert property (take_a && rst_a_i |=> data_a_o == '0)
        else $error("port A output reset failed");
    a_clear_b: assert property (take_b && rst_b_port_i |=> data_b_o == '0)
        else $error("port B output reset failed");
    a_apb_ready: assert property (acc_seq |-> pready_o)
        else $error("no ready in access phase");
    a_apb_err: assert property (acc_seq |-> pslverr_o == (paddr_i != 'h0 && paddr_i != 'h4))
        else $error("error flag does not match address map");
    a_err_idle: assert property (!(psel_i && penable_i) |-> !pslverr_o)
        else $error("error flag outside access phase");
endmodule // dpram_chk

bind dual_port_block_ram dpram_chk #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) u_chk (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .port_clock_a_i(port_clock_a_i), .en_a_i(en_a_i), .we_a_i(we_a_i), .rst_a_i(rst_a_i),
    .port_data_in_a_i(port_data_in_a_i), .data_a_o(data_a_o),
    .port_clock_b_i(port_clock_b_i), .en_b_i(en_b_i), .we_b_i(we_b_i),
    .rst_b_port_i(rst_b_port_i), .port_data_in_b_i(port_data_in_b_i), .data_b_o(data_b_o));

// ===== port_user.sv
// Behavioural user logic driving one memory port
`timescale 1ns/10ps
module port_user #(
    parameter W  = 4,
    parameter AW = 10
) (
    input  wire logic           mclk_i,
    output logic                port_clock_o = 1'b0,
    output logic                en_o = 1'b0,
    output logic                we_o = 1'b0,
    output logic                rst_o = 1'b0,
    output logic [AW-1:0]       addr_o = '0,
    output logic [W-1:0]        din_o = '0
);
    // ------------------------------------------------------------
    // One port operation, held a full mclk cycle around the edge
    // ------------------------------------------------------------
    task automatic op(input logic e, w, r, input logic [AW-1:0] a, input logic [W-1:0] d);
        @(posedge mclk_i);
        port_clock_o <= 1'b1;
        en_o <= e;
        we_o <= w;
        rst_o <= r;
        addr_o <= a;
        din_o <= d;
        @(posedge mclk_i);
        port_clock_o <= 1'b0;
        en_o <= 1'b0;
        // Released buses show the inverse so a late sample cannot match by luck
        addr_o <= ~a;
        din_o <= ~d;
    endtask
endmodule // port_user

// ===== dual_port_block_ram_tb.sv
// Self-checking testbench for the dual-port block memory
`timescale 1ns/10ps
module dual_port_block_ram_tb;
    localparam WA = 4, WB = 16, AWA = 10, AWB = 8;
    typedef struct {logic b, en, we, rs; logic [15:0] a, d, x;} row_t;
    logic mclk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0, rd;
    logic er;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, pca, ena, wea, rsa, pcb, enb, web, rsb;
    wire [AWA-1:0] ada;
    wire [AWB-1:0] adb;
    wire [WA-1:0] dia, data_a_o;
    wire [WB-1:0] dib, data_b_o;
    int err_total = 0, comparisons = 0;
    row_t rows[0:13] = '{'{1,1,0,0,0,0,0}, '{0,1,1,0,0,'hA,'hA}, '{0,1,1,0,1,5,5},
        '{0,1,1,0,3,'hC,'hC}, '{1,1,0,0,0,0,'hC05A}, '{1,1,1,0,255,'h1234,'h1234},
        '{0,1,0,0,1023,0,1}, '{0,1,0,0,1020,0,4}, '{0,1,0,1,0,0,0}, '{1,1,0,0,0,0,'hC05A},
        '{0,0,1,0,0,'hF,0}, '{0,1,0,0,0,0,'hA}, '{0,0,0,1,0,0,'hA}, '{0,1,0,0,2,0,0}};

    dual_port_block_ram #(.WIDTH_A(WA), .WIDTH_B(WB)) uut (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .paddr_i(paddr_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .port_clock_a_i(pca), .en_a_i(ena),
        .we_a_i(wea), .rst_a_i(rsa), .addr_a_i(ada), .port_data_in_a_i(dia),
        .data_a_o(data_a_o), .port_clock_b_i(pcb), .en_b_i(enb), .we_b_i(web),
        .rst_b_port_i(rsb), .addr_b_i(adb), .port_data_in_b_i(dib), .data_b_o(data_b_o));
    port_user #(.W(WA), .AW(AWA)) u_pa (.mclk_i(mclk_i), .port_clock_o(pca), .en_o(ena),
        .we_o(wea), .rst_o(rsa), .addr_o(ada), .din_o(dia));
    port_user #(.W(WB), .AW(AWB)) u_pb (.mclk_i(mclk_i), .port_clock_o(pcb), .en_o(enb),
        .we_o(web), .rst_o(rsb), .addr_o(adb), .din_o(dib));

    initial
    begin
        forever #20 mclk_i = ~mclk_i;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s, e);
        comparisons++;
        if (s !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(negedge mclk_i);
        while (pready_o !== 1'b1)
        begin
            @(posedge mclk_i);
            @(negedge mclk_i);
        end
        rd = prdata_o;
        er = pslverr_o;
        @(posedge mclk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].b)
                u_pb.op(rows[i].en, rows[i].we, rows[i].rs, rows[i].a[AWB-1:0], rows[i].d);
            else
                u_pa.op(rows[i].en, rows[i].we, rows[i].rs, rows[i].a[AWA-1:0], rows[i].d[3:0]);
            @(negedge mclk_i);
            chk("row out", rows[i].b ? {16'h0, data_b_o} : {28'h0, data_a_o}, 32'(rows[i].x));
        end
        $display("table rows done");
        fork
            u_pa.op(1, 1, 0, 8, 4'h3);
            u_pb.op(1, 1, 0, 5, 16'hBEEF);
        join
        @(negedge mclk_i);
        chk("same edge A", {28'h0, data_a_o}, 32'h3);
        chk("same edge B", {16'h0, data_b_o}, 32'hBEEF);
        u_pb.op(1, 0, 0, 2, 16'h0);
        @(negedge mclk_i);
        chk("narrow in wide", {16'h0, data_b_o}, 32'h3);
        fork
            u_pa.op(1, 1, 0, 0, 4'h1);
            u_pb.op(1, 1, 0, 0, 16'h00F0);
        join
        @(negedge mclk_i);
        chk("collide A", {28'h0, data_a_o}, 32'h1);
        chk("collide B", {16'h0, data_b_o}, 32'hF0);
        u_pa.op(1, 0, 0, 0, 4'h0);
        apb(0, 12'h004, 32'h0);
        chk("status", rd, 32'h5);
        apb(1, 12'h004, 32'hF);
        apb(0, 12'h004, 32'h0);
        chk("status clear", rd, 32'h0);
        $display("dual port tests done");
        apb(1, 12'h000, 32'hFFFF_FFF5);
        apb(0, 12'h000, 32'h0);
        chk("ctrl", {rd[31:1], er}, 32'h4);
        apb(0, 12'h008, 32'h0);
        chk("unmapped", {rd[31:1], er}, 32'h1);
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        @(negedge mclk_i);
        chk("reset outs", {data_b_o, 12'h0, data_a_o}, 32'h0);
        apb(0, 12'h000, 32'h0);
        chk("ctrl after reset", rd, 32'h0);
        u_pb.op(1, 0, 0, 0, 16'h0);
        @(negedge mclk_i);
        chk("array after reset", {16'h0, data_b_o}, 32'h0);
        $display("register and reset tests done");
        final_report();
    end
    initial
    begin
        #80000;
        err_total++;
        final_report();
    end
endmodule // dual_port_block_ram_tb
